// ==== common/eth_pause_params.svh ====
/*
  offsets, field positions, reset values and timing counts of the pause
  flow control block. assumes inclusion by name from the package and the
  design files; holds definitions only.
*/
`ifndef ETH_PAUSE_PARAMS_SVH
`define ETH_PAUSE_PARAMS_SVH

`define OFS_CTRL 8'h00
`define OFS_TXQ 8'h04
`define OFS_FILT 8'h08
`define OFS_STA_LO 8'h0C
`define OFS_STA_HI 8'h10
`define OFS_UNI_LO 8'h14
`define OFS_UNI_HI 8'h18
`define OFS_STAT 8'h1C
`define OFS_CNT 8'h20

`define CTRL_XOFF 0
`define CTRL_XON 1
`define CTRL_UNI 2
`define CTRL_HONOR 3
`define FILT_EN 0
`define FILT_PAUSE 4
`define FILT_CTRL 5

`define RST_HONOR 1'b1
`define RST_UNI 1'b0
`define RST_TXQ 16'hFFFF
`define RST_FILT_EN 1'b1
`define RST_DROP 1'b1

`define MCAST_DA 48'h0180_C200_0001
`define ETH_TYPE_CTL 16'h8808
`define OPC_PAUSE 16'h0001
`define PREAMBLE_WORD 64'hFB55_5555_5555_55D5
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320

`define BIT_TIMES_PER_QUANTA 512
`define DATA_BITS 64
`define QUANTA_CYCLES (`BIT_TIMES_PER_QUANTA / `DATA_BITS)
`define FRAME_WORDS 9

`endif

// ==== common/eth_pause_pkg.sv ====
/*
  types shared by the pause flow control design files.
  assumes the params header is on the include path.
*/
`include "eth_pause_params.svh"

package eth_pause_pkg;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAUSE = 3'b100
  } tx_state_t;

endpackage : eth_pause_pkg

// ==== hdl/pause_frame_builder.sv ====
/*
  builds one pause frame as nine 64-bit words: preamble, addresses,
  type, opcode, quanta, pad and crc. assumes a start pulse only while idle
  and a sink that takes one word per cycle.
*/
`timescale 1ns/1ps
`include "eth_pause_params.svh"

module pause_frame_builder (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic [47:0] dst,
  input wire logic [47:0] src,
  input wire logic [15:0] quanta,
  output logic [63:0] word,
  output logic valid,
  output logic first,
  output logic last
);

  logic [3:0] idx_r;
  logic busy_r;
  logic [47:0] dst_r;
  logic [47:0] src_r;
  logic [15:0] quanta_r;
  logic [31:0] crc_r;
  logic [31:0] crcFin;

  // reflected crc-32 over the leading n bytes of a word
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [63:0] d, input int n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        r = r ^ {24'h00_0000, d[63-8*i -: 8]};
        for (int b = 0; b < 8; b++) begin
          r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
      end
    end
    return r;
  endfunction : crc_upd

  always_ff @(posedge clock) begin
    if (reset) begin
      busy_r <= 1'b0;
      idx_r <= 4'h0;
    end else if (start) begin
      busy_r <= 1'b1;
      idx_r <= 4'h0;
    end else if (busy_r) begin
      idx_r <= idx_r + 4'h1;
      if (idx_r == 4'(`FRAME_WORDS - 1)) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (start) begin
      dst_r <= dst;
      src_r <= src;
      quanta_r <= quanta;
    end
  end

  always_ff @(posedge clock) begin
    if (start) begin
      crc_r <= `CRC_INIT;
    end else if (busy_r && idx_r != 4'h0) begin
      crc_r <= crc_upd(crc_r, word, 8);
    end
  end

  // last word: four pad bytes then the inverted crc, low byte first
  assign crcFin = ~crc_upd(crc_r, 64'h0, 4);

  always_comb begin
    case (idx_r)
      4'h0: word = `PREAMBLE_WORD;
      4'h1: word = {dst_r, src_r[47:32]};
      4'h2: word = {src_r[31:0], `ETH_TYPE_CTL, `OPC_PAUSE};
      4'h3: word = {quanta_r, 48'h0000_0000_0000};
      4'h8: word = {32'h0000_0000, crcFin[7:0], crcFin[15:8], crcFin[23:16], crcFin[31:24]};
      default: word = 64'h0;
    endcase
  end

  assign valid = busy_r;
  assign first = busy_r && idx_r == 4'h0;
  assign last = busy_r && idx_r == 4'(`FRAME_WORDS - 1);

endmodule : pause_frame_builder

// ==== hdl/ethernet_pause_flow_control.sv ====
/*
  pause flow control for a 64-bit ethernet mac: rx pause detection and
  filtering, tx pause timer and pause frame insertion, apb registers.
  assumes one 40 mhz clock, contiguous rx frames, same-clock client logic.
*/
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "eth_pause_params.svh"

module ethernet_pause_flow_control (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pauseReq,
  input wire logic [15:0] pauseReqQuanta,
  input wire logic pauseReqGroup,
  input wire logic [47:0] pauseReqDst,
  input wire logic [47:0] pauseReqSrc,
  input wire logic [63:0] txInData,
  input wire logic txInValid,
  input wire logic txInSof,
  input wire logic txInEof,
  output logic txInReady,
  output logic [63:0] txOutData,
  output logic txOutValid,
  output logic txOutSof,
  output logic txOutEof,
  output logic txOutIsPause,
  input wire logic tx_pause_hit_in,
  input wire logic [15:0] tx_pause_quanta_in,
  input wire logic [63:0] rxData,
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  output logic [63:0] rxOutData,
  output logic rxOutValid,
  output logic rxOutSof,
  output logic rxOutEof,
  output logic rxPauseHit,
  output logic [15:0] rxPauseQuanta
);

  localparam int QC = `QUANTA_CYCLES;

  // software registers
  logic uni_r;
  logic honor_r;
  logic [15:0] txQuanta_r;
  logic filtEn_r;
  logic dropPause_r;
  logic dropCtrl_r;
  logic [47:0] station_r;
  logic [47:0] unicast_r;
  logic [15:0] rxHitCnt_r;
  logic [15:0] txPauseCnt_r;

  // apb slave
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic apbAcc;
  logic wrEn;
  logic [31:0] readVal;

  // client and host requests
  logic reqDly_r;
  logic reqRise;
  logic cPend_r;
  logic [15:0] cQuanta_r;
  logic cGroup_r;
  logic [47:0] cDst_r;
  logic [47:0] cSrc_r;
  logic hPend_r;
  logic hXoff_r;
  logic hostSet;
  logic cTake;
  logic hTake;
  logic cPendNxt;
  logic hPendNxt;

  // tx path
  eth_pause_pkg::tx_state_t state_r;
  eth_pause_pkg::tx_state_t stateNxt;
  logic inTake;
  logic txInReady_r;
  logic readyNxt;
  logic [63:0] txOutData_r;
  logic txOutValid_r;
  logic txOutSof_r;
  logic txOutEof_r;
  logic txOutIsPause_r;
  logic [47:0] bDst;
  logic [47:0] bSrc;
  logic [15:0] bQuanta;
  logic [63:0] bldWord;
  logic bldValid;
  logic bldFirst;
  logic bldLast;

  // pause timer
  logic [15:0] cnt_r;
  logic [15:0] cntNxt;
  logic [2:0] sub_r;
  logic [2:0] subNxt;
  logic loadPend_r;
  logic loadPendNxt;
  logic [15:0] loadQ_r;
  logic hitAcc;
  logic [15:0] hitQ;
  logic apply;

  // rx path
  logic [63:0] s1Data_r;
  logic s1Valid_r;
  logic s1Sof_r;
  logic s1Eof_r;
  logic [1:0] rxIdx_r;
  logic secWord;
  logic isCtl;
  logic isPau;
  logic dropCls;
  logic dropCur;
  logic dropFrame_r;
  logic pauseFr_r;
  logic match_r;
  logic [15:0] rxQ_r;
  logic rxPauseHit_r;
  logic [15:0] rxPauseQuanta_r;
  logic [63:0] rxOutData_r;
  logic rxOutValid_r;
  logic rxOutSof_r;
  logic rxOutEof_r;

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `OFS_CTRL || a == `OFS_TXQ || a == `OFS_FILT || a == `OFS_STA_LO ||
           a == `OFS_STA_HI || a == `OFS_UNI_LO || a == `OFS_UNI_HI || a == `OFS_STAT ||
           a == `OFS_CNT;
  endfunction : addr_ok

  // apb: one wait state, write lands at the pready edge
  assign apbAcc = psel && penable && !pready_r;
  assign wrEn = psel && penable && pready_r && pwrite && addr_ok(paddr);

  always_comb begin
    readVal = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: readVal = {28'h000_0000, honor_r, uni_r, 2'b00};
      `OFS_TXQ: readVal = {16'h0000, txQuanta_r};
      `OFS_FILT: readVal = {26'h000_0000, dropCtrl_r, dropPause_r, 3'b000, filtEn_r};
      `OFS_STA_LO: readVal = station_r[31:0];
      `OFS_STA_HI: readVal = {16'h0000, station_r[47:32]};
      `OFS_UNI_LO: readVal = unicast_r[31:0];
      `OFS_UNI_HI: readVal = {16'h0000, unicast_r[47:32]};
      `OFS_STAT: readVal = {cnt_r, 13'h0000, state_r != eth_pause_pkg::TX_IDLE, cPend_r || hPend_r, cnt_r != 16'h0000};
      `OFS_CNT: readVal = {txPauseCnt_r, rxHitCnt_r};
      default: readVal = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apbAcc;
      if (apbAcc) begin
        pslverr_r <= !addr_ok(paddr);
        prdata_r <= (pwrite || !addr_ok(paddr)) ? 32'h0000_0000 : readVal;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      uni_r <= `RST_UNI;
      honor_r <= `RST_HONOR;
      txQuanta_r <= `RST_TXQ;
      filtEn_r <= `RST_FILT_EN;
      dropPause_r <= `RST_DROP;
      dropCtrl_r <= `RST_DROP;
      station_r <= 48'h0000_0000_0000;
      unicast_r <= 48'h0000_0000_0000;
    end else if (wrEn) begin
      case (paddr)
        `OFS_CTRL: begin
          uni_r <= pwdata[`CTRL_UNI];
          honor_r <= pwdata[`CTRL_HONOR];
        end
        `OFS_TXQ: txQuanta_r <= pwdata[15:0];
        `OFS_FILT: begin
          filtEn_r <= pwdata[`FILT_EN];
          dropPause_r <= pwdata[`FILT_PAUSE];
          dropCtrl_r <= pwdata[`FILT_CTRL];
        end
        `OFS_STA_LO: station_r[31:0] <= pwdata;
        `OFS_STA_HI: station_r[47:32] <= pwdata[15:0];
        `OFS_UNI_LO: unicast_r[31:0] <= pwdata;
        `OFS_UNI_HI: unicast_r[47:32] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // client strobe edge and latched request fields
  assign reqRise = pauseReq && !reqDly_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      reqDly_r <= 1'b0;
    end else begin
      reqDly_r <= pauseReq;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cPend_r <= 1'b0;
    end else begin
      cPend_r <= cPendNxt;
    end
    if (reqRise) begin
      cQuanta_r <= pauseReqQuanta;
      cGroup_r <= pauseReqGroup;
      cDst_r <= pauseReqDst;
      cSrc_r <= pauseReqSrc;
    end
  end

  // host xoff/xon request, xoff wins if both bits written
  assign hostSet = wrEn && paddr == `OFS_CTRL && (pwdata[`CTRL_XOFF] || pwdata[`CTRL_XON]);

  always_ff @(posedge clock) begin
    if (reset) begin
      hPend_r <= 1'b0;
      hXoff_r <= 1'b0;
    end else begin
      hPend_r <= hPendNxt;
      if (hostSet) begin
        hXoff_r <= pwdata[`CTRL_XOFF];
      end
    end
  end

  // new requests win over the take in the same cycle
  assign cPendNxt = (cPend_r && !cTake) || reqRise;
  assign hPendNxt = (hPend_r && !hTake) || hostSet;

  // tx arbitration
  always_comb begin
    stateNxt = state_r;
    cTake = 1'b0;
    hTake = 1'b0;
    inTake = txInValid && txInReady_r;
    case (state_r)
      eth_pause_pkg::TX_IDLE: begin
        if (inTake && txInSof && !txInEof) begin
          stateNxt = eth_pause_pkg::TX_DATA;
        end else if (cPend_r && !inTake) begin
          cTake = 1'b1;
          stateNxt = eth_pause_pkg::TX_PAUSE;
        end else if (hPend_r && !inTake) begin
          hTake = 1'b1;
          stateNxt = eth_pause_pkg::TX_PAUSE;
        end
      end
      eth_pause_pkg::TX_DATA: begin
        if (inTake && txInEof) begin
          stateNxt = eth_pause_pkg::TX_IDLE;
        end
      end
      eth_pause_pkg::TX_PAUSE: begin
        if (bldLast) begin
          stateNxt = eth_pause_pkg::TX_IDLE;
        end
      end
      default: stateNxt = eth_pause_pkg::TX_IDLE;
    endcase
  end

  // new data frames start only when idle, unpaused and no pause frame queued
  always_comb begin
    if (stateNxt == eth_pause_pkg::TX_DATA) begin
      readyNxt = 1'b1;
    end else begin
      readyNxt = stateNxt == eth_pause_pkg::TX_IDLE && !cPendNxt && !hPendNxt &&
                 cntNxt == 16'h0000 && !loadPendNxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= eth_pause_pkg::TX_IDLE;
      txInReady_r <= 1'b0;
    end else begin
      state_r <= stateNxt;
      txInReady_r <= readyNxt;
    end
  end

  // pause frame fields
  always_comb begin
    if (cTake) begin
      bDst = cGroup_r ? `MCAST_DA : cDst_r;
      bSrc = cSrc_r;
      bQuanta = cQuanta_r;
    end else begin
      bDst = uni_r ? unicast_r : `MCAST_DA;
      bSrc = station_r;
      bQuanta = hXoff_r ? txQuanta_r : 16'h0000;
    end
  end

  pause_frame_builder builder (
    .clock(clock),
    .reset(reset),
    .start(cTake || hTake),
    .dst(bDst),
    .src(bSrc),
    .quanta(bQuanta),
    .word(bldWord),
    .valid(bldValid),
    .first(bldFirst),
    .last(bldLast)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      txOutValid_r <= 1'b0;
      txOutSof_r <= 1'b0;
      txOutEof_r <= 1'b0;
      txOutIsPause_r <= 1'b0;
      txOutData_r <= 64'h0;
    end else if (state_r == eth_pause_pkg::TX_PAUSE && bldValid) begin
      txOutValid_r <= 1'b1;
      txOutSof_r <= bldFirst;
      txOutEof_r <= bldLast;
      txOutIsPause_r <= 1'b1;
      txOutData_r <= bldWord;
    end else if (inTake && (state_r == eth_pause_pkg::TX_DATA || txInSof)) begin
      txOutValid_r <= 1'b1;
      txOutSof_r <= txInSof;
      txOutEof_r <= txInEof;
      txOutIsPause_r <= 1'b0;
      txOutData_r <= txInData;
    end else begin
      txOutValid_r <= 1'b0;
      txOutSof_r <= 1'b0;
      txOutEof_r <= 1'b0;
      txOutIsPause_r <= 1'b0;
    end
  end

  // pause timer: loads only outside a data frame
  assign hitAcc = honor_r && (rxPauseHit_r || tx_pause_hit_in);
  assign hitQ = rxPauseHit_r ? rxPauseQuanta_r : tx_pause_quanta_in;
  assign apply = loadPend_r && state_r != eth_pause_pkg::TX_DATA;
  assign loadPendNxt = hitAcc || (loadPend_r && !apply);

  always_comb begin
    cntNxt = cnt_r;
    subNxt = sub_r;
    if (apply) begin
      cntNxt = loadQ_r;
      subNxt = 3'h0;
    end else if (cnt_r != 16'h0000) begin
      if (sub_r == 3'(QC - 1)) begin
        cntNxt = cnt_r - 16'h0001;
        subNxt = 3'h0;
      end else begin
        subNxt = sub_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_r <= 16'h0000;
      sub_r <= 3'h0;
      loadPend_r <= 1'b0;
      loadQ_r <= 16'h0000;
    end else begin
      cnt_r <= cntNxt;
      sub_r <= subNxt;
      loadPend_r <= loadPendNxt;
      if (hitAcc) begin
        loadQ_r <= hitQ;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rxHitCnt_r <= 16'h0000;
      txPauseCnt_r <= 16'h0000;
    end else begin
      if (rxPauseHit_r) begin
        rxHitCnt_r <= rxHitCnt_r + 16'h0001;
      end
      if (bldLast) begin
        txPauseCnt_r <= txPauseCnt_r + 16'h0001;
      end
    end
  end

  // rx: one word of delay so the drop decision covers the first word
  always_ff @(posedge clock) begin
    if (reset) begin
      s1Valid_r <= 1'b0;
      s1Sof_r <= 1'b0;
      s1Eof_r <= 1'b0;
      s1Data_r <= 64'h0;
    end else begin
      s1Valid_r <= rxValid;
      s1Sof_r <= rxValid && rxSof;
      s1Eof_r <= rxValid && rxEof;
      s1Data_r <= rxData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rxIdx_r <= 2'h0;
    end else if (rxValid) begin
      if (rxSof) begin
        rxIdx_r <= 2'h1;
      end else if (rxIdx_r != 2'h3) begin
        rxIdx_r <= rxIdx_r + 2'h1;
      end
    end
  end

  assign secWord = rxValid && !rxSof && rxIdx_r == 2'h1;
  assign isCtl = rxData[31:16] == `ETH_TYPE_CTL;
  assign isPau = isCtl && rxData[15:0] == `OPC_PAUSE;
  assign dropCls = filtEn_r && ((isPau && dropPause_r) || (isCtl && !isPau && dropCtrl_r));
  assign dropCur = s1Sof_r ? (secWord && dropCls) : dropFrame_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      dropFrame_r <= 1'b0;
      pauseFr_r <= 1'b0;
      match_r <= 1'b0;
    end else if (rxValid && rxSof) begin
      dropFrame_r <= 1'b0;
      pauseFr_r <= 1'b0;
      match_r <= rxData[63:16] == `MCAST_DA || rxData[63:16] == station_r;
    end else if (secWord) begin
      dropFrame_r <= dropCls;
      pauseFr_r <= isPau;
    end
  end

  always_ff @(posedge clock) begin
    if (rxValid && !rxSof && rxIdx_r == 2'h2) begin
      rxQ_r <= rxData[63:48];
    end
  end

  // hit raised whether the frame is forwarded or dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      rxPauseHit_r <= 1'b0;
      rxPauseQuanta_r <= 16'h0000;
    end else begin
      rxPauseHit_r <= rxValid && rxEof && !rxSof && pauseFr_r && match_r && rxIdx_r == 2'h3;
      if (rxValid && rxEof && pauseFr_r && match_r) begin
        rxPauseQuanta_r <= rxQ_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rxOutValid_r <= 1'b0;
      rxOutSof_r <= 1'b0;
      rxOutEof_r <= 1'b0;
      rxOutData_r <= 64'h0;
    end else begin
      rxOutValid_r <= s1Valid_r && !dropCur;
      rxOutSof_r <= s1Sof_r && !dropCur;
      rxOutEof_r <= s1Eof_r && !dropCur;
      rxOutData_r <= s1Data_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txInReady = txInReady_r;
  assign txOutData = txOutData_r;
  assign txOutValid = txOutValid_r;
  assign txOutSof = txOutSof_r;
  assign txOutEof = txOutEof_r;
  assign txOutIsPause = txOutIsPause_r;
  assign rxOutData = rxOutData_r;
  assign rxOutValid = rxOutValid_r;
  assign rxOutSof = rxOutSof_r;
  assign rxOutEof = rxOutEof_r;
  assign rxPauseHit = rxPauseHit_r;
  assign rxPauseQuanta = rxPauseQuanta_r;

endmodule : ethernet_pause_flow_control

// ==== verif/pause_props.sv ====
/*
  port-level properties of the pause flow control block.
  assumes binding to the top module, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "eth_pause_params.svh"
module pause_props (
  input wire logic clock,
  input wire logic reset,
  input wire logic [63:0] txOutData,
  input wire logic txOutValid,
  input wire logic txOutSof,
  input wire logic txOutEof,
  input wire logic txOutIsPause,
  input wire logic [63:0] rxData,
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  input wire logic rxOutSof,
  input wire logic rxPauseHit,
  input wire logic [15:0] rxPauseQuanta
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_start;
    txOutValid && txOutSof && txOutIsPause;
  endsequence
  sequence s_body;
    (txOutValid && txOutIsPause && !txOutEof)[*8];
  endsequence
  property p_len;
    s_start |-> s_body ##1 (txOutValid && txOutIsPause && txOutEof);
  endproperty
  property p_pre;
    s_start |-> txOutData == `PREAMBLE_WORD;
  endproperty
  property p_type;
    s_start |-> ##2 txOutData[31:0] == {`ETH_TYPE_CTL, `OPC_PAUSE};
  endproperty
  property p_pad;
    s_start |-> ##4 (txOutData == 64'h0000_0000_0000_0000)[*4];
  endproperty
  property p_hit_pulse;
    rxPauseHit |=> !rxPauseHit;
  endproperty
  property p_hit_eof;
    rxPauseHit |-> $past(rxValid && rxEof);
  endproperty
  property p_hit_q;
    rxPauseHit |-> rxPauseQuanta == $past(rxData[63:48], 2);
  endproperty
  property p_fwd;
    rxOutSof |-> $past(rxSof, 2);
  endproperty
  a_len: assert property (p_len) else $error("pause frame length wrong");
  a_pre: assert property (p_pre) else $error("pause preamble wrong");
  a_type: assert property (p_type) else $error("pause type wrong");
  a_pad: assert property (p_pad) else $error("pause pad wrong");
  a_hit_pulse: assert property (p_hit_pulse) else $error("hit too long");
  a_hit_eof: assert property (p_hit_eof) else $error("hit without eof");
  a_hit_q: assert property (p_hit_q) else $error("hit quanta wrong");
  a_fwd: assert property (p_fwd) else $error("rx sof not delayed");
endmodule : pause_props

// ==== verif/link_partner.sv ====
/*
  remote mac model: sends pause frames into the rx stream.
  assumes frames start at the destination address, no preamble.
*/
`timescale 1ns/1ps
`include "eth_pause_params.svh"
module link_partner (
  input wire logic clock,
  output logic [63:0] rxData,
  output logic rxValid,
  output logic rxSof,
  output logic rxEof
);
  initial begin
    rxData = 64'h0000_0000_0000_0000;
    rxValid = 1'h0;
    rxSof = 1'h0;
    rxEof = 1'h0;
  end
  task automatic send(input logic [47:0] da, input logic [15:0] q);
    logic [63:0] w [4];
    w[0] = {da, 16'h0000};
    w[1] = {32'h0000_0000, `ETH_TYPE_CTL, `OPC_PAUSE};
    w[2] = {q, 48'h0000_0000_0000};
    w[3] = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      rxData <= w[i];
      rxValid <= 1'h1;
      rxSof <= (i == 0);
      rxEof <= (i == 3);
    end
    @(posedge clock);
    rxData <= ~w[3];
    rxValid <= 1'h0;
    rxEof <= 1'h0;
  endtask : send
endmodule : link_partner

// ==== verif/testbench.sv ====
/*
  self-checking bench of the pause flow control block.
  assumes the design files, partner model and checker are compiled.
*/
`timescale 1ns/1ps
`include "eth_pause_params.svh"
module testbench;
  logic clock = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, pauseReq = 1'h0, pauseReqGroup = 1'h0;
  logic [15:0] pauseReqQuanta = 16'h0000, tx_pause_quanta_in = 16'h0000, rxPauseQuanta, q, hs;
  logic [47:0] pauseReqDst = 48'h0000_0000_0000, pauseReqSrc = 48'h0000_0000_0000, u;
  logic [63:0] txInData = 64'h0000_0000_0000_0000, txOutData, rxData, rxOutData;
  logic txInValid = 1'h0, txInSof = 1'h0, txInEof = 1'h0, txInReady, tx_pause_hit_in = 1'h0;
  logic txOutValid, txOutSof, txOutEof, txOutIsPause, rxValid, rxSof, rxEof;
  logic rxOutValid, rxOutSof, rxOutEof, rxPauseHit;
  int miscompares = 0, compares = 0, cyc = 0, nFrames = 0, nRx = 0, wi = 0, n;
  logic [47:0] dq [$], sq [$];
  logic [15:0] qq [$];
  logic [63:0] tq [$];
  always #12.5 clock = ~clock;
  ethernet_pause_flow_control dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pauseReq(pauseReq), .pauseReqQuanta(pauseReqQuanta), .pauseReqGroup(pauseReqGroup),
    .pauseReqDst(pauseReqDst), .pauseReqSrc(pauseReqSrc), .txInData(txInData), .txInValid(txInValid),
    .txInSof(txInSof), .txInEof(txInEof), .txInReady(txInReady), .txOutData(txOutData),
    .txOutValid(txOutValid), .txOutSof(txOutSof), .txOutEof(txOutEof), .txOutIsPause(txOutIsPause),
    .tx_pause_hit_in(tx_pause_hit_in), .tx_pause_quanta_in(tx_pause_quanta_in), .rxData(rxData),
    .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof), .rxOutData(rxOutData), .rxOutValid(rxOutValid),
    .rxOutSof(rxOutSof), .rxOutEof(rxOutEof), .rxPauseHit(rxPauseHit), .rxPauseQuanta(rxPauseQuanta));
  link_partner lp (.clock(clock), .rxData(rxData), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof));
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task creq(input logic [15:0] rq, input logic g);
    logic [47:0] d;
    d = 48'({$urandom(), $urandom()});
    @(posedge clock);
    pauseReq <= 1'h1;
    pauseReqQuanta <= rq;
    pauseReqGroup <= g;
    pauseReqDst <= d;
    dq.push_back(g ? `MCAST_DA : d);
    sq.push_back(pauseReqSrc);
    qq.push_back(rq);
    repeat (30) @(posedge clock);
    pauseReq <= 1'h0;
  endtask : creq
  task sendData(input int len);
    logic [63:0] w;
    @(posedge clock);
    for (int i = 0; i < len; i++) begin
      w = {$urandom(), $urandom()};
      txInData <= w;
      txInValid <= 1'h1;
      txInSof <= (i == 0);
      txInEof <= (i == len - 1);
      do @(posedge clock); while (txInReady !== 1'h1);
      tq.push_back(w);
    end
    txInValid <= 1'h0;
  endtask : sendData
  task xhit(input logic [15:0] xq);
    @(posedge clock);
    tx_pause_hit_in <= 1'h1;
    tx_pause_quanta_in <= xq;
    @(posedge clock);
    tx_pause_hit_in <= 1'h0;
  endtask : xhit
  task pauseTime;
    n = 0;
    repeat (2) @(posedge clock);
    while (txInReady !== 1'h1) begin
      n++;
      @(posedge clock);
    end
  endtask : pauseTime
  always @(posedge clock) begin
    if (txOutValid === 1'h1 && txOutIsPause === 1'h1) begin
      if (txOutSof === 1'h1) wi = 0;
      if (wi == 1) check("dst", txOutData[63:16], dq.pop_front());
      if (wi == 1) hs = txOutData[15:0];
      if (wi == 2) check("src", {hs, txOutData[63:32]}, sq.pop_front());
      if (wi == 3) check("quanta", txOutData[63:48], qq.pop_front());
      if (txOutEof === 1'h1) nFrames++;
      wi++;
    end else if (txOutValid === 1'h1) check("data", txOutData, tq.pop_front());
    if (rxOutValid === 1'h1) nRx++;
    if (rxOutSof === 1'h1) check("rxsof", rxOutData, {`MCAST_DA, 16'h0000});
  end
  always @(posedge clock) begin
    if (++cyc > 60000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    rd = $urandom(32'h3db8);
    pauseReqSrc = 48'({$urandom(), $urandom()});
    repeat (4) @(posedge clock);
    reset <= 1'h0;
    apb(1'h0, `OFS_CTRL, 32'h0000_0000);
    check("ctrl", rd, 32'h0000_0008);
    apb(1'h0, `OFS_FILT, 32'h0000_0000);
    check("filt", rd, 32'h0000_0031);
    apb(1'h0, 8'h40, 32'h0000_0000);
    check("slverr", err, 1'h1);
    creq(16'($urandom_range(1, 65535)), 1'h1);
    creq(16'h0000, 1'h0);
    repeat (20) @(posedge clock);
    check("frames", nFrames, 2);
    q = 16'($urandom());
    dq.push_back(`MCAST_DA);
    sq.push_back(48'h0000_0000_0000);
    qq.push_back(q);
    apb(1'h1, `OFS_TXQ, {16'h0000, q});
    apb(1'h1, `OFS_CTRL, 32'h0000_0009);
    repeat (20) @(posedge clock);
    u = 48'({$urandom(), $urandom()});
    dq.push_back(u);
    sq.push_back(48'h0000_0000_0000);
    qq.push_back(16'h0000);
    apb(1'h1, `OFS_UNI_LO, u[31:0]);
    apb(1'h1, `OFS_UNI_HI, {16'h0000, u[47:32]});
    apb(1'h1, `OFS_CTRL, 32'h0000_000E);
    apb(1'h1, `OFS_CTRL, 32'h0000_0008);
    repeat (20) @(posedge clock);
    check("frames", nFrames, 4);
    sendData(3);
    for (int k = 0; k < 2; k++) begin
      lp.send(`MCAST_DA, 16'h0004);
      @(posedge clock);
      check("rxq", rxPauseQuanta, 16'h0004);
      pauseTime();
      check("pause", n >= 26 && n <= 34, 1'h1);
      check("rxfwd", nRx, 4 * k);
      apb(1'h1, `OFS_FILT, 32'h0000_0001);
    end
    xhit(16'h0100);
    repeat (20) @(posedge clock);
    xhit(16'h0002);
    pauseTime();
    check("newest", n >= 12 && n <= 18, 1'h1);
    xhit(16'h0100);
    repeat (20) @(posedge clock);
    xhit(16'h0000);
    pauseTime();
    check("resume", n < 8, 1'h1);
    fork
      sendData(12);
      begin
        repeat (4) @(posedge clock);
        xhit(16'h0002);
      end
    join
    pauseTime();
    check("midframe", n >= 12 && n <= 18, 1'h1);
    apb(1'h1, `OFS_CTRL, 32'h0000_0000);
    xhit(16'h0100);
    pauseTime();
    check("honour", n, 0);
    sendData(2);
    repeat (10) @(posedge clock);
    finish_test();
  end
endmodule : testbench
bind ethernet_pause_flow_control pause_props u_props (.clock(clock), .reset(reset), .txOutData(txOutData),
  .txOutValid(txOutValid), .txOutSof(txOutSof), .txOutEof(txOutEof), .txOutIsPause(txOutIsPause),
  .rxData(rxData), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof), .rxOutSof(rxOutSof),
  .rxPauseHit(rxPauseHit), .rxPauseQuanta(rxPauseQuanta));
